/* logic/wfchp_host_port.v */
// Host port of a disk-controller board: backplane select decode, interrupt
// request and vector logic, sector buffer with error code, Wishbone registers.
// Assumes jumpers and backplane lines arrive as raw pins, the disk side is
// logic on clk, and a classic Wishbone master on clk.
//
// How it works
// - Width jumpers pick 16, 24 or 32-bit addressing.
// - Address lines 15..4, 23..4 or 31..4 by width compared against jumpered base.
// - Fitted jumper reads zero, removed reads one.
// - Factory default is 24-bit, fixed base.
// - Enable jumper decides if modifier lines count.
// - Modifier code compared in parallel with address.
// - First request on completion or error.
// - Second request when data needed or ready.
// - Each request has its own enable jumper.
// - Requests routable to seven levels, ack matches.
// - Default jumpers leave both interrupts off.
// - Interrupt vectors are software programmable.
// - All data passes the byte-wide sector buffer.
// - Sector sizes 128, 256, 512 or 1024.
// - Append four code bytes, check syndrome, retry.
// - Bursts of up to five bits are correctable.
// - Floppy selection translates commands to floppy ops.
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "wfchp_defs.vh"

module wfchp_host_port (
  input wire clk, // Board clock, 25 MHz
  input wire rst_b, // Synchronous reset, low
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte lanes
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire [31:4] busAddr, // Backplane address pins
  input wire [5:0] busModifier, // Backplane modifier pins
  input wire busAddrStrobe_b, // Backplane address strobe, low
  input wire widthJumperA, // Width jumper, 1 = pins 2-3
  input wire widthJumperB, // Width jumper, 1 = pins 2-3
  input wire [31:4] baseJumpers, // Base jumpers, low = fitted
  input wire [5:0] modifierCodeJumpers, // Modifier code jumpers
  input wire modifierDecodeEnableJumper, // High = modifier decode on
  input wire [2:0] requestLevelJumpersA, // Level of completion request
  input wire [2:0] requestLevelJumpersB, // Level of data request
  input wire [2:0] ackLevelJumperA, // Ack level for completion
  input wire [2:0] ackLevelJumperB, // Ack level for data request
  input wire completionIrqEnableJumper, // High = completion irq on
  input wire dataRequestIrqEnableJumper, // High = data irq on
  input wire iackCycle, // Interrupt acknowledge in progress
  input wire [2:0] iackLevel, // Level being acknowledged
  input wire [7:0] diskInData, // Byte from disk controller
  input wire diskInValid, // Disk byte valid
  input wire diskOutReady, // Disk side takes a byte
  output reg boardSelect_r, // Backplane cycle claimed
  output reg [7:1] irqLines_r, // Request lines, one per level
  output reg [7:0] vectorOut_r, // Vector during acknowledge
  output reg vectorValid_r, // Vector being presented
  output reg [7:0] diskOutData_r, // Byte to disk controller
  output reg diskOutValid_r, // Disk output byte valid
  output reg diskStart_r, // Pulse: start disk operation
  output reg [1:0] diskOp_r, // Operation for disk side
  output reg floppySelect_r, // Floppy controller targeted
  output reg diskRetry_r // Pulse: reread the sector
);

  localparam ST_IDLE = 3'h0;
  localparam ST_FILL = 3'h1;
  localparam ST_SEND = 3'h2;
  localparam ST_RECV = 3'h3;
  localparam ST_DRAIN = 3'h4;

  wire [`WFCHP_SYNC_WIDTH-1:0] pinsRaw;
  wire [`WFCHP_SYNC_WIDTH-1:0] pinsSync;
  wire [31:4] sAddr;
  wire [5:0] sMod;
  wire sStrobe;
  wire [1:0] sWidth;
  wire [31:4] sBase;
  wire [5:0] sModCode;
  wire sModEn;
  wire [2:0] sReqLvlA;
  wire [2:0] sReqLvlB;
  wire [2:0] sAckLvlA;
  wire [2:0] sAckLvlB;
  wire sEnA;
  wire sEnB;
  wire sIack;
  wire [2:0] sIackLvl;
  reg [7:0] sectorBuf [0:2047];
  reg [2:0] state_r;
  reg [1:0] sizeSel_r;
  reg [7:0] drvHead_r;
  reg [7:0] vec1_r;
  reg [7:0] vec2_r;
  reg [10:0] ptr_r;
  reg [2:0] codeCnt_r;
  reg [1:0] retry_r;
  reg donePend_r;
  reg error_r;
  reg eccError_r;
  reg correctable_r;
  reg [27:0] addrMask;
  reg addrMatch;
  reg modMatch;
  reg widthOk;
  wire [11:0] secLen;
  wire bufFull;
  wire eccMode;
  wire wbReq;
  wire wbWr;
  wire dataAccess;
  wire [31:0] eccCode;
  wire eccClear;
  wire eccValid;
  wire [7:0] eccByteIn;
  wire [31:0] statusWord;
  wire dataReqLevel;
  wire [7:0] reqHotA;
  wire [7:0] reqHotB;

  // Strobe enters inverted so cleared sync stages read as no cycle
  assign pinsRaw = {busAddr, busModifier, ~busAddrStrobe_b, widthJumperA, widthJumperB,
    baseJumpers, modifierCodeJumpers, modifierDecodeEnableJumper, requestLevelJumpersA,
    requestLevelJumpersB, ackLevelJumperA, ackLevelJumperB, completionIrqEnableJumper,
    dataRequestIrqEnableJumper, iackCycle, iackLevel};

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  wfchp_sync #(
    .WIDTH(`WFCHP_SYNC_WIDTH)
  ) uSync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn(pinsRaw),
    .syncOut_r(pinsSync)
  );

  assign {sAddr, sMod, sStrobe, sWidth, sBase, sModCode, sModEn, sReqLvlA, sReqLvlB,
    sAckLvlA, sAckLvlB, sEnA, sEnB, sIack, sIackLvl} = pinsSync;

  // ****************************************************************
  // Backplane select decode
  // ****************************************************************
  // Width selects which address lines take part; the crossed jumper pair is
  // not a legal option, so that board never answers rather than guessing
  always @*
  begin
    addrMask = 28'h0000000;
    widthOk = 1'b1;
    case (sWidth)
      `WFCHP_WIDTH_A16: addrMask = 28'h0000FFF;
      `WFCHP_WIDTH_A24: addrMask = 28'h00FFFFF;
      `WFCHP_WIDTH_A32: addrMask = 28'hFFFFFFF;
      default: widthOk = 1'b0;
    endcase
    // jumper pin level is bit value
    addrMatch = ((sAddr ^ sBase) & addrMask) == 28'h0000000;
    modMatch = !sModEn || (sMod == sModCode);
  end

  // Claim held for the whole strobe
  always @(posedge clk)
  begin
    if (!rst_b)
      boardSelect_r <= 1'b0;
    else
      boardSelect_r <= sStrobe && widthOk && addrMatch && modMatch;
  end

  // ****************************************************************
  // Sector length, code mode and buffer state
  // ****************************************************************
  // four sector sizes
  assign secLen = `WFCHP_MIN_SECTOR << sizeSel_r;
  assign bufFull = {1'b0, ptr_r} == secLen;
  // code bit low means check format for floppies
  assign eccMode = drvHead_r[`WFCHP_DH_ECC_BIT];

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
  assign dataAccess = wbReq && (wb_adr_i == `WFCHP_OFS_DATA);

  // ****************************************************************
  // Error code unit
  // ****************************************************************
  assign eccClear = (state_r == ST_IDLE) || diskRetry_r;
  assign eccValid = ((state_r == ST_FILL) && wbWr && dataAccess && !bufFull) ||
    ((state_r == ST_RECV) && diskInValid);
  assign eccByteIn = (state_r == ST_RECV) ? diskInData : wb_dat_i[7:0];

  wfchp_ecc uEcc (
    .clk(clk),
    .rst_b(rst_b),
    .clear(eccClear),
    .byteValid(eccValid),
    .byteIn(eccByteIn),
    .code_r(eccCode)
  );

  // ****************************************************************
  // Transfer sequencer and sector buffer
  // ****************************************************************
  // Every data byte lands in the buffer first; the host side and disk side never
  // meet directly, which costs latency but keeps the disk side free-running
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      ptr_r <= 11'h000;
      codeCnt_r <= 3'h0;
      retry_r <= 2'h0;
      donePend_r <= 1'b0;
      error_r <= 1'b0;
      eccError_r <= 1'b0;
      correctable_r <= 1'b0;
      diskOutData_r <= 8'h00;
      diskOutValid_r <= 1'b0;
      diskStart_r <= 1'b0;
      diskOp_r <= 2'h0;
      floppySelect_r <= 1'b0;
      diskRetry_r <= 1'b0;
    end
    else
    begin
      diskStart_r <= 1'b0;
      diskRetry_r <= 1'b0;
      // Reading status clears completion; a new completion in that cycle wins
      if (wbReq && !wb_we_i && (wb_adr_i == `WFCHP_OFS_STATUS))
        donePend_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          diskOutValid_r <= 1'b0;
          if (wbWr && (wb_adr_i == `WFCHP_OFS_CTRL) && wb_dat_i[`WFCHP_CTRL_START_BIT])
          begin
            ptr_r <= 11'h000;
            codeCnt_r <= 3'h0;
            retry_r <= 2'h0;
            error_r <= 1'b0;
            eccError_r <= 1'b0;
            correctable_r <= 1'b0;
            diskOp_r <= wb_dat_i[`WFCHP_CTRL_OP_LSB+1:`WFCHP_CTRL_OP_LSB];
            floppySelect_r <= drvHead_r[`WFCHP_DH_FLOPPY_BIT];
            if (wb_dat_i[`WFCHP_CTRL_OP_LSB+1:`WFCHP_CTRL_OP_LSB] == `WFCHP_OP_READ)
            begin
              diskStart_r <= 1'b1;
              state_r <= ST_RECV;
            end
            else
              state_r <= ST_FILL;
          end
        end
        ST_FILL:
        begin
          if (wbWr && dataAccess && !bufFull)
          begin
            sectorBuf[ptr_r] <= wb_dat_i[7:0];
            ptr_r <= ptr_r + 11'h001;
          end
          if (bufFull && wbWr && (wb_adr_i == `WFCHP_OFS_CTRL) && wb_dat_i[`WFCHP_CTRL_GO_BIT])
          begin
            ptr_r <= 11'h000;
            diskStart_r <= 1'b1;
            state_r <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (!diskOutValid_r || diskOutReady)
          begin
            if (!bufFull)
            begin
              diskOutData_r <= sectorBuf[ptr_r];
              diskOutValid_r <= 1'b1;
              ptr_r <= ptr_r + 11'h001;
            end
            else if (eccMode && (codeCnt_r != `WFCHP_ECC_BYTES))
            begin
              diskOutData_r <= eccCode[8*(3-codeCnt_r[1:0])+:8];
              diskOutValid_r <= 1'b1;
              codeCnt_r <= codeCnt_r + 3'h1;
            end
            else
            begin
              diskOutValid_r <= 1'b0;
              donePend_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RECV:
        begin
          if (diskInValid && !bufFull)
          begin
            sectorBuf[ptr_r] <= diskInData;
            ptr_r <= ptr_r + 11'h001;
          end
          else if (diskInValid && eccMode && (codeCnt_r != `WFCHP_ECC_BYTES))
            codeCnt_r <= codeCnt_r + 3'h1;
          if (bufFull && (!eccMode || (codeCnt_r == `WFCHP_ECC_BYTES)) && !diskInValid)
          begin
            if (!eccMode || (eccCode == 32'h0000_0000))
            begin
              ptr_r <= 11'h000;
              state_r <= ST_DRAIN;
            end
            else if (retry_r != `WFCHP_RETRY_MAX)
            begin
              retry_r <= retry_r + 2'h1;
              ptr_r <= 11'h000;
              codeCnt_r <= 3'h0;
              diskRetry_r <= 1'b1;
            end
            else
            begin
              eccError_r <= 1'b1;
              correctable_r <= eccCode[31:`WFCHP_BURST_MAX] == 27'h0000000;
              error_r <= 1'b1;
              donePend_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_DRAIN:
        begin
          if (wbReq && !wb_we_i && dataAccess)
          begin
            if ({1'b0, ptr_r} == secLen - 12'h001)
            begin
              donePend_r <= 1'b1;
              state_r <= ST_IDLE;
            end
            ptr_r <= ptr_r + 11'h001;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Interrupt requests and acknowledge
  // ****************************************************************
  // data needed or data ready
  assign dataReqLevel = ((state_r == ST_FILL) && !bufFull) || (state_r == ST_DRAIN);
  assign reqHotA = {7'h00, sEnA && donePend_r} << sReqLvlA;
  assign reqHotB = {7'h00, sEnB && dataReqLevel} << sReqLvlB;

  // Levels come from jumpers only; a zero level jumper parks the request
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      irqLines_r <= 7'h00;
      vectorOut_r <= 8'h00;
      vectorValid_r <= 1'b0;
    end
    else
    begin
      irqLines_r <= reqHotA[7:1] | reqHotB[7:1];
      vectorValid_r <= 1'b0;
      vectorOut_r <= 8'h00;
      if (sIack && sEnA && donePend_r && (sIackLvl == sAckLvlA))
      begin
        vectorOut_r <= vec1_r;
        vectorValid_r <= 1'b1;
      end
      else if (sIack && sEnB && dataReqLevel && (sIackLvl == sAckLvlB))
      begin
        vectorOut_r <= vec2_r;
        vectorValid_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Wishbone registers
  // ****************************************************************
  // flag when width and base jumpers sit at factory setting
  assign statusWord = {21'h000000, (sWidth == `WFCHP_WIDTH_A24) && (sBase == `WFCHP_FACTORY_BASE),
    (sReqLvlA != sAckLvlA) || (sReqLvlB != sAckLvlB), !widthOk, correctable_r, eccError_r,
    error_r, donePend_r, dataReqLevel, bufFull, state_r != ST_IDLE, boardSelect_r};

  // One-cycle answer for every address, unmapped ones read zero
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `WFCHP_RST_DATA;
      sizeSel_r <= `WFCHP_RST_SIZE;
      drvHead_r <= `WFCHP_RST_DRVHEAD;
      vec1_r <= `WFCHP_RST_VEC;
      vec2_r <= `WFCHP_RST_VEC;
    end
    else
    begin
      wb_ack_o <= wbReq;
      if (wbWr && (state_r == ST_IDLE))
      begin
        case (wb_adr_i)
          `WFCHP_OFS_SIZE: sizeSel_r <= wb_dat_i[1:0];
          `WFCHP_OFS_DRVHEAD: drvHead_r <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      if (wbWr && (wb_adr_i == `WFCHP_OFS_VEC1))
        vec1_r <= wb_dat_i[7:0];
      if (wbWr && (wb_adr_i == `WFCHP_OFS_VEC2))
        vec2_r <= wb_dat_i[7:0];
      if (wbReq && !wb_we_i)
      begin
        case (wb_adr_i)
          `WFCHP_OFS_CTRL: wb_dat_o <= {27'h0000000, state_r, diskOp_r};
          `WFCHP_OFS_STATUS: wb_dat_o <= statusWord;
          `WFCHP_OFS_DATA: wb_dat_o <= {24'h000000, sectorBuf[ptr_r]};
          `WFCHP_OFS_SIZE: wb_dat_o <= {30'h00000000, sizeSel_r};
          `WFCHP_OFS_DRVHEAD: wb_dat_o <= {24'h000000, drvHead_r};
          `WFCHP_OFS_VEC1: wb_dat_o <= {24'h000000, vec1_r};
          `WFCHP_OFS_VEC2: wb_dat_o <= {24'h000000, vec2_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule

/* logic/wfchp_defs.vh */
// Constants of the disk-controller host port: register map, fields, resets.
// Assumes inclusion by bare name from the design files of this block.
`ifndef WFCHP_DEFS_VH
`define WFCHP_DEFS_VH

// ****************************************************************
// Register byte offsets, one 32-bit word each
// ****************************************************************
`define WFCHP_OFS_CTRL 8'h00
`define WFCHP_OFS_STATUS 8'h04
`define WFCHP_OFS_DATA 8'h08
`define WFCHP_OFS_SIZE 8'h0C
`define WFCHP_OFS_DRVHEAD 8'h10
`define WFCHP_OFS_VEC1 8'h14
`define WFCHP_OFS_VEC2 8'h18

// ****************************************************************
// Control register fields
// ****************************************************************
`define WFCHP_CTRL_OP_LSB 0
`define WFCHP_CTRL_START_BIT 2
`define WFCHP_CTRL_GO_BIT 3
`define WFCHP_OP_READ 2'h0
`define WFCHP_OP_WRITE 2'h1
`define WFCHP_OP_FORMAT 2'h2

// ****************************************************************
// Drive/head select fields
// ****************************************************************
`define WFCHP_DH_ECC_BIT 7
`define WFCHP_DH_FLOPPY_BIT 6

// ****************************************************************
// Reset values
// ****************************************************************
`define WFCHP_RST_SIZE 2'h2
`define WFCHP_RST_DRVHEAD 8'h80
`define WFCHP_RST_VEC 8'h0F
`define WFCHP_RST_DATA 32'h0000_0000

// ****************************************************************
// Addressing, buffer and code constants
// ****************************************************************
`define WFCHP_WIDTH_A16 2'h0
`define WFCHP_WIDTH_A24 2'h1
`define WFCHP_WIDTH_A32 2'h3
`define WFCHP_FACTORY_BASE 28'h00B0100
`define WFCHP_MIN_SECTOR 12'h080
`define WFCHP_ECC_BYTES 3'h4
`define WFCHP_BURST_MAX 5
`define WFCHP_RETRY_MAX 2'h3
`define WFCHP_ECC_POLY 32'h04C11DB7
`define WFCHP_SYNC_WIDTH 90

`endif

/* logic/wfchp_sync.v */
// Two-stage synchroniser for a bundle of pin-level inputs.
// Assumes each bit is a slow level; no bit is read from the first stage.
`timescale 1ns/1ps

module wfchp_sync #(
  parameter WIDTH = 8
) (
  input wire clk, // Board clock
  input wire rst_b, // Synchronous reset, low
  input wire [WIDTH-1:0] asyncIn, // Pin levels
  output reg [WIDTH-1:0] syncOut_r // Levels in clock domain
);

  reg [WIDTH-1:0] meta_r;

  // ****************************************************************
  // Two flip-flops, first stage feeds only the second
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_r <= {WIDTH{1'b0}};
      syncOut_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= asyncIn;
      syncOut_r <= meta_r;
    end
  end

endmodule

/* logic/wfchp_ecc.v */
// Four-byte error code generator and checker, byte-serial, MSB first.
// Assumes the caller clears it before each sector and feeds bytes in order.
`timescale 1ns/1ps
`include "wfchp_defs.vh"

module wfchp_ecc (
  input wire clk, // Board clock
  input wire rst_b, // Synchronous reset, low
  input wire clear, // Restart the code for a new sector
  input wire byteValid, // Byte present this cycle
  input wire [7:0] byteIn, // Data or received code byte
  output reg [31:0] code_r // Running remainder
);

  reg [31:0] codeNxt;
  reg fb;
  integer i;

  // Eight division steps per byte; the remainder is zero after a clean
  // sector plus its own code, so one register serves write and check
  always @*
  begin
    codeNxt = code_r;
    fb = 1'b0;
    for (i = 7; i >= 0; i = i - 1)
    begin
      fb = codeNxt[31] ^ byteIn[i];
      codeNxt = {codeNxt[30:0], 1'b0} ^ (fb ? `WFCHP_ECC_POLY : 32'h0000_0000);
    end
  end

  // ****************************************************************
  // Remainder register
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!rst_b)
      code_r <= 32'h0000_0000;
    else if (clear)
      code_r <= 32'h0000_0000;
    else if (byteValid)
      code_r <= codeNxt;
  end

endmodule

/* verif/wfchp_host_port_sva.sv */
// Checker on host port outputs: bus answer, claim, vector, disk pulses.
// Assumes binding into every wfchp_host_port instance.
`timescale 1ns/1ps
module wfchp_host_port_sva (
  input wire clk, // Clock
  input wire rst_b, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_ack_o, // Ack
  input wire [31:0] wb_dat_o, // Read data
  input wire busAddrStrobe_b, // Strobe pin
  input wire boardSelect_r, // Claim
  input wire iackCycle, // Iack
  input wire vectorValid_r, // Vector on
  input wire diskStart_r, // Start
  input wire diskRetry_r, // Retry
  input wire diskOutValid_r, // Byte out
  input wire diskOutReady // Byte taken
);
  // ****
  // Sequences
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Pins idle long enough to pass the two sync stages and the output register
  sequence s_strobeIdle; busAddrStrobe_b [*4]; endsequence
  sequence s_iackIdle; !iackCycle [*4]; endsequence
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // ****
  // Assertions
  // ****
  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("no ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  a_claim_strobe: assert property (s_strobeIdle |-> !boardSelect_r)
    else $error("claim without strobe");
  a_vec_iack: assert property (s_iackIdle |-> !vectorValid_r)
    else $error("vector without iack");
  a_start_pulse: assert property (diskStart_r |=> !diskStart_r)
    else $error("start too long");
  a_retry_pulse: assert property (diskRetry_r |=> !diskRetry_r)
    else $error("retry too long");
  a_byte_held: assert property (diskOutValid_r && !diskOutReady |=> diskOutValid_r)
    else $error("byte dropped");
endmodule

bind wfchp_host_port wfchp_host_port_sva i_sva (.*);

/* verif/wfchp_disk_model.sv */
// Disk-side partner: takes the byte stream out, sends sectors back.
// Assumes the bench sets the resend length and whether to spoil a byte.
`timescale 1ns/1ps
module wfchp_disk_model (
  input wire clk, // Clock
  input wire rst_b, // Reset
  input wire diskStart_r, // Start
  input wire [1:0] diskOp_r, // Operation
  input wire diskRetry_r, // Resend
  input wire diskOutValid_r, // Byte out
  input wire [11:0] sendLen, // Bytes to send
  input wire spoil, // Spoil first byte
  output reg diskOutReady, // Take byte
  output reg [7:0] diskInData, // Byte in
  output reg diskInValid, // Byte in valid
  output reg [11:0] rxCount // Bytes taken
);
  reg [11:0] left;
  // Stalls every other cycle; idle data toggles so no stale byte looks valid
  always @(posedge clk)
  begin
    diskOutReady <= rst_b & ~diskOutReady;
    diskInValid <= 1'b0;
    diskInData <= ~diskInData;
    if (!rst_b)
    begin
      left <= 12'h000;
      rxCount <= 12'h000;
      diskInData <= 8'h00;
    end
    else
    begin
      if (diskOutValid_r && diskOutReady)
        rxCount <= rxCount + 12'h001;
      if (diskRetry_r || (diskStart_r && diskOp_r == 2'h0))
        left <= sendLen;
      else if (left != 12'h000 && !diskInValid)
      begin
        diskInValid <= 1'b1;
        diskInData <= (spoil && left == sendLen) ? 8'h01 : 8'h00;
        left <= left - 12'h001;
      end
    end
  end
endmodule

/* verif/wfchp_host_port_tb_top.sv */
// Bench: registers, select decode, sector write and read, vectors.
// Assumes the disk partner and the bound checker beside the design.
`timescale 1ns/1ps
module wfchp_host_port_tb_top;
  reg clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, busAddrStrobe_b, widthJumperA, widthJumperB;
  reg modifierDecodeEnableJumper, completionIrqEnableJumper, dataRequestIrqEnableJumper;
  reg iackCycle, spoil;
  reg [7:0] wb_adr_i;
  reg [31:0] wb_dat_i, rd;
  reg [31:4] busAddr, baseJumpers;
  reg [5:0] busModifier, modifierCodeJumpers;
  reg [2:0] iackLevel;
  reg [11:0] sendLen;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, boardSelect_r, vectorValid_r, diskOutValid_r, diskStart_r, floppySelect_r;
  wire diskRetry_r, diskInValid, diskOutReady;
  wire [7:1] irqLines_r;
  wire [7:0] vectorOut_r, diskOutData_r, diskInData;
  wire [1:0] diskOp_r;
  wire [11:0] rxCount;
  integer mismatches, cmp_count, cycles, retries, i;
  // ****
  // Design and disk partner; levels 3 and 4 fixed for the two requests
  // ****
  wfchp_host_port i_dut (.*, .wb_sel_i(4'hF), .requestLevelJumpersA(3'h3),
    .requestLevelJumpersB(3'h4), .ackLevelJumperA(3'h3), .ackLevelJumperB(3'h4));
  wfchp_disk_model i_disk (.*);
  // Clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, retry pulse count, outgoing sector bytes
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (diskRetry_r === 1'b1)
      retries = retries + 1;
    if (diskOutValid_r && diskOutReady && rxCount < 12'h080)
      check(diskOutData_r, rxCount);
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  task check(input [31:0] seen, input [31:0] want);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== want)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t: saw %h, want %h", $time, seen, want);
    end
  end
  endtask
  // Classic single cycle, held until ack is sampled
  task wb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1)
      @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  end
  endtask
  // Backplane cycle; waits out the pin sync latency before judging
  task dec(input [31:4] a, input [5:0] m, input want);
  begin
    busAddr <= a;
    busModifier <= m;
    busAddrStrobe_b <= 1'b0;
    repeat (5) @(posedge clk);
    check(boardSelect_r, want);
    busAddrStrobe_b <= 1'b1;
    repeat (5) @(posedge clk);
  end
  endtask
  task report_and_stop;
  begin
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task test_regs;
  begin
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      wb(1'b1, 8'h0C, i);
      wb(1'b0, 8'h0C, 32'h0);
      check(rd, i);
    end
    wb(1'b1, 8'h14, 32'h5A);
    wb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h5A);
    $display("regs test done");
  end
  endtask
  task test_decode;
  begin
    wb(1'b0, 8'h04, 32'h0);
    check(rd[10], 1'b1);
    dec(28'h00B0100, 6'h3D, 1'b1);
    dec(28'h00B0101, 6'h3D, 1'b0);
    dec(28'h01B0100, 6'h3D, 1'b1);
    dec(28'h00B0100, 6'h39, 1'b0);
    modifierCodeJumpers <= 6'h39;
    dec(28'h00B0100, 6'h39, 1'b1);
    modifierDecodeEnableJumper <= 1'b0;
    dec(28'h00B0100, 6'h0D, 1'b1);
    widthJumperA <= 1'b1;
    dec(28'h01B0100, 6'h0D, 1'b0);
    widthJumperB <= 1'b0;
    dec(28'h00B0100, 6'h0D, 1'b0);
    widthJumperA <= 1'b0;
    dec(28'h0000100, 6'h0D, 1'b1);
    widthJumperB <= 1'b1;
    $display("decode test done");
  end
  endtask
  task test_write;
  begin
    completionIrqEnableJumper <= 1'b1;
    dataRequestIrqEnableJumper <= 1'b1;
    wb(1'b1, 8'h0C, 32'h0);
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b0, 8'h04, 32'h0);
    check(irqLines_r, 7'h08);
    for (i = 0; i < 128; i = i + 1)
      wb(1'b1, 8'h08, i);
    wb(1'b0, 8'h04, 32'h0);
    check(rd[2], 1'b1);
    wb(1'b1, 8'h00, 32'h9);
    while (rxCount !== 12'h084)
      @(posedge clk);
    repeat (8) @(posedge clk);
    check(rxCount, 32'h84);
    check(irqLines_r, 7'h04);
    iackCycle <= 1'b1;
    iackLevel <= 3'h3;
    repeat (4) @(posedge clk);
    check({vectorValid_r, vectorOut_r}, 9'h15A);
    iackCycle <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    check(rd[4], 1'b1);
    repeat (4) @(posedge clk);
    check(irqLines_r, 7'h00);
    $display("write test done");
  end
  endtask
  // Good floppy read, or a spoiled coded read that must exhaust its retries
  task test_read(input sp);
  begin
    spoil <= sp;
    sendLen <= sp ? 12'h084 : 12'h080;
    wb(1'b1, 8'h10, sp ? 32'h80 : 32'h40);
    retries = 0;
    wb(1'b1, 8'h00, 32'h4);
    repeat (2) @(posedge clk);
    check(floppySelect_r, !sp);
    rd = 32'h0;
    while (rd[3] !== 1'b1 && rd[5] !== 1'b1)
      wb(1'b0, 8'h04, 32'h0);
    check(rd[6:4], sp ? 3'h7 : 3'h0);
    check(retries, sp ? 32'h3 : 32'h0);
    for (i = 0; i < (sp ? 0 : 128); i = i + 1)
    begin
      wb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
    end
    wb(1'b0, 8'h04, 32'h0);
    check(rd[4], !sp);
    $display("read test done");
  end
  endtask
  // Main sequence
  initial
  begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, iackCycle, spoil, widthJumperA} = 7'h00;
    {busAddrStrobe_b, widthJumperB, modifierDecodeEnableJumper} = 3'h7;
    {completionIrqEnableJumper, dataRequestIrqEnableJumper} = 2'h0;
    {wb_adr_i, wb_dat_i, iackLevel, sendLen, busAddr, busModifier} = 89'h0;
    baseJumpers = 28'h00B0100;
    modifierCodeJumpers = 6'h3D;
    {mismatches, cmp_count, cycles, retries} = 128'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    check(boardSelect_r, 1'b0);
    test_regs;
    test_decode;
    test_write;
    test_read(1'b0);
    test_read(1'b1);
    report_and_stop;
  end
endmodule
